// ==== ssp_far_master.sv ====
`timescale 1ns/1ns
module ssp_far_master (
    // Pins
    input wire ssp_pkg::ssp_pin_out_t pinOut,
    output ssp_pkg::ssp_pin_in_t pinIn
);
    import ssp_pkg::*;
    logic sclDrv = 1'h1;
    logic sdaDrv = 1'h1;
    logic ssn = 1'h1;
    logic lastSdo = 1'h0;
    // Pull-ups on both open-drain lines
    assign pinIn.sclIn = sclDrv & (pinOut.sclOe_n | pinOut.sclOut);
    assign pinIn.sdaIn = sdaDrv & (pinOut.sdaOe_n | pinOut.sdaOut);
    assign pinIn.ssnIn = ssn;
    // A floating data out shows the inverse of its last level
    wire sdoSeen = pinOut.sdoOe_n ? ~lastSdo : pinOut.sdoOut;
    always @(pinOut) if (!pinOut.sdoOe_n) lastSdo = pinOut.sdoOut;
    //////////////////////////////////////////////////////////////////////
    task automatic spi(input logic clock_polarity_release_bit, input logic cke,
        input logic [7:0] tx, input logic [3:0] n, output logic [7:0] rx);
        #3 sclDrv = clock_polarity_release_bit;
        #200 ssn = 1'h0;
        #200;
        for (int i = 0; i < n; i++) begin
            if (cke) sdaDrv = tx[7 - i];
            #40 if (cke) rx[7 - i] = sdoSeen;
            sclDrv = ~clock_polarity_release_bit;
            if (!cke) sdaDrv = tx[7 - i];
            #40 if (!cke) rx[7 - i] = sdoSeen;
            sclDrv = clock_polarity_release_bit;
        end
        #40 ssn = 1'h1;
        #200;
    endtask : spi
    task automatic i2c(input logic st, input logic [8:0] b,
        output logic [8:0] rx);
        #3 if (st) begin
            sdaDrv = 1'h1;
            #100 sclDrv = 1'h1;
            #100 sdaDrv = 1'h0;
            #100 sclDrv = 1'h0;
        end
        for (int i = 8; i >= 0; i--) begin
            #20 sdaDrv = b[i];
            #80 sclDrv = 1'h1;
            wait (pinIn.sclIn);
            #50 rx[i] = pinIn.sdaIn;
            #50 sclDrv = 1'h0;
        end
    endtask : i2c
    task automatic stop;
        #20 sdaDrv = 1'h0;
        #100 sclDrv = 1'h1;
        #100 sdaDrv = 1'h1;
        #200;
    endtask : stop
endmodule : ssp_far_master

// ==== ssp_monitor.sv ====
`timescale 1ns/1ns
module ssp_monitor #(
    parameter int DIV_HALF = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Power and pins
    input wire logic sleep,
    input wire ssp_pkg::ssp_pin_in_t pinIn,
    input wire ssp_pkg::ssp_pin_out_t pinOut,
    // Events
    input wire logic portIrq,
    input wire logic wakeReq
);
    import ssp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence sReq;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence sAck;
        ack_o ##1 !ack_o;
    endsequence
    //////////////////////////////////////////////////////////////////////
    chk_ack_once: assert property (sReq |=> sAck)
        else $error("bus answer not a single pulse");
    chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_wake_cause: assert property (wakeReq |-> sleep && portIrq)
        else $error("wake request without sleep and flag");
    chk_irq_clear: assert property ($fell(portIrq) |->
        $past(ack_o && we_i && adr_i[7:2] == OFS_IRQ[7:2]))
        else $error("flag dropped without software write");
    chk_od_low: assert property (!pinOut.sdaOe_n |-> !pinOut.sdaOut)
        else $error("data pin driven high");
    chk_sdo_gate: assert property (pinIn.ssnIn [*6] |-> pinOut.sdoOe_n)
        else $error("data out driven while deselected");
    chk_reset_idle: assert property (disable iff (1'b0)
        $rose(rstn) |-> pinOut.sdaOe_n && pinOut.sclOe_n
        && pinOut.sdoOe_n && !portIrq)
        else $error("outputs not idle after reset");
    chk_ack_low_scl: assert property ($fell(pinOut.sdaOe_n)
        |-> !pinIn.sclIn)
        else $error("data pin changed while clock high");
    chk_stretch_hold: assert property ($rose(pinOut.sclOe_n) |->
        $past(ack_o && we_i && (adr_i[7:2] == OFS_CON[7:2]
        || adr_i[7:2] == OFS_ADDR[7:2]), 2))
        else $error("clock released without software");
endmodule : ssp_monitor
bind ssp_sync_serial ssp_monitor #(.DIV_HALF(DIV_HALF)) ssp_monitor_inst (
    .clk(clk), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .sleep(sleep), .pinIn(pinIn), .pinOut(pinOut),
    .portIrq(portIrq), .wakeReq(wakeReq));

// ==== ssp_pkg.sv ====
package ssp_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_BUF = 8'h00;
    localparam logic [7:0] OFS_CON = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_DIR = 8'h10;
    localparam logic [7:0] OFS_IRQ = 8'h14;
    // serial_control fields
    localparam int CON_WRITE_COLLISION_FLAG = 7;
    localparam int CON_OV = 6;
    localparam int CON_EN = 5;
    localparam int CON_CKP = 4;
    // serial_status fields
    localparam int ST_SMP = 7;
    localparam int ST_CKE = 6;
    localparam int ST_DA = 5;
    localparam int ST_P = 4;
    localparam int ST_S = 3;
    localparam int ST_RW = 2;
    localparam int ST_UA = 1;
    localparam int ST_BF = 0;
    // Interrupt flag register fields
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_EN = 1;
    // Reset value of every stored bit
    localparam logic [7:0] REG_RST = 8'h00;
    // port_mode_field codes
    localparam logic [3:0] MODE_SPI_SS = 4'h4;
    localparam logic [3:0] MODE_SPI_NOSS = 4'h5;
    localparam logic [3:0] MODE_I2C_7 = 4'h6;
    localparam logic [3:0] MODE_I2C_10 = 4'h7;
    localparam logic [3:0] MODE_I2C_M = 4'h8;
    localparam logic [3:0] MODE_I2C_FW = 4'hB;
    localparam logic [3:0] MODE_I2C_7S = 4'hE;
    localparam logic [3:0] MODE_I2C_10S = 4'hF;
    // Counts
    localparam logic [4:0] TEN_HDR = 5'h1E;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [4:0] EDGE_LAST = 5'h0F;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_RX = 3'b001,
        I_ACK = 3'b010,
        I_HOLD = 3'b011,
        I_TX = 3'b100,
        I_MACK = 3'b101
    } ssp_i2c_st_t;

    typedef struct packed {
        logic sclIn;
        logic sdaIn;
        logic ssnIn;
    } ssp_pin_in_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe_n;
        logic sdaOut;
        logic sdaOe_n;
        logic sdoOut;
        logic sdoOe_n;
    } ssp_pin_out_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [7:0] buffer;
        logic write_collision_flag;
        logic ov;
        logic en;
        logic clock_polarity_release_bit;
        logic [3:0] mode;
        logic sample_phase_bit;
        logic cke;
        logic dataAddr;
        logic stopSeen;
        logic startSeen;
        logic readWrite;
        logic updAddr;
        logic bufFull;
        logic [7:0] slvAddr;
        logic [3:0] dirOut;
        logic irqFlag;
        logic irqEn;
        logic [2:0] sclS;
        logic [2:0] sdaS;
        logic [1:0] ssnS;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic outBit;
        ssp_i2c_st_t ist;
        logic [1:0] phase;
        logic tenMatched;
        logic ackBit;
        logic holdReq;
        logic busy;
        logic [7:0] div;
        logic intSck;
        logic [4:0] edges;
    } ssp_state_t;
endpackage : ssp_pkg

// ==== ssp_sync_serial.sv ====
`timescale 1ns/1ns
// Functional notes
// - Mode code 04h alone makes slave-select gate the SPI slave transfer.
// - With select control, shift and drive data out only while select low.
// - Select rising releases data output two clocks later, even mid-byte.
// - Select high (mode 0100) or port disable resets SPI, bit count zero.
// - SPI master freezes its transfer in sleep and resumes on wake.
// - SPI slave shifts during sleep; eighth bit sets flag, may wake.
// - Any reset disables the port and abandons the transfer.
// - Master modes 00,01,10,11 set clock half-period to 1,4,16,16 times DIV_HALF.
// - Enabled I2C slave modes drive clock and data open-drain if set as inputs.
// - Mode field picks master, 7/10-bit slave, start/stop irq, firmware.
// - I2C slave waits for start, shifts eight bits on clock rising.
// - Shift bits 7:1 compared with slave address at eighth clock fall.
// - Match with buffer free: load buffer, set full, ACK, flag at ninth.
// - Buffer full or overflow: no ACK, buffer kept, flag still set.
// - Buffer read clears full; overflow only cleared by software.
// - 10-bit first byte is 11110 A9 A8 write, then a low byte follows.
// - 10-bit address bytes set flag, full, update and stretch clock.
// - Write direction match clears read bit, loads address, flags bytes.
// - Read match sets read bit, ACKs, stretches until release bit set.
// - Slave transmitter shifts eight bits out on clock falling edges.
// - Master ACK latched at ninth rise; NACK resets, ACK waits release.
module ssp_sync_serial #(
    parameter int DIV_HALF = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Device power state
    input wire logic sleep,
    // Pins
    input wire ssp_pkg::ssp_pin_in_t pinIn,
    output ssp_pkg::ssp_pin_out_t pinOut,
    // Event outputs
    output logic portIrq,
    output logic wakeReq
);
    import ssp_pkg::*;

    initial begin
        if (DIV_HALF < 1 || DIV_HALF > 16) begin
            $error("DIV_HALF must be 1 to 16");
        end
    end

    ssp_state_t s;
    ssp_state_t n;

    ////////////////////////////////////////////////////////////////////
    // Decodes and pin events
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic sdiBit;
    logic ssHigh;
    logic isSpiSlave;
    logic isSpiMaster;
    logic isI2cSlave;
    logic isI2c;
    logic isTen;
    logic ssIrq;
    logic acc;
    logic wrLow;
    logic rdAcc;
    logic [7:0] regAdr;
    logic [31:0] readMux;

    assign sclRise = s.sclS[1] & ~s.sclS[2];
    assign sclFall = ~s.sclS[1] & s.sclS[2];
    assign startCond = s.sclS[1] & s.sclS[2] & ~s.sdaS[1] & s.sdaS[2];
    assign stopCond = s.sclS[1] & s.sclS[2] & s.sdaS[1] & ~s.sdaS[2];
    assign sdiBit = s.sdaS[1];
    assign ssHigh = s.ssnS[1];
    assign isSpiSlave = (s.mode == MODE_SPI_SS) |
        (s.mode == MODE_SPI_NOSS);
    assign isSpiMaster = (s.mode[3:2] == 2'b00);
    assign isI2cSlave = (s.mode == MODE_I2C_7) | (s.mode == MODE_I2C_10) |
        (s.mode == MODE_I2C_7S) | (s.mode == MODE_I2C_10S);
    assign isI2c = isI2cSlave | (s.mode == MODE_I2C_M) |
        (s.mode == MODE_I2C_FW);
    assign isTen = s.mode[0];
    assign ssIrq = s.mode[3];
    assign regAdr = {adr_i[7:2], 2'b00};
    assign acc = cyc_i & stb_i & s.ack;
    assign wrLow = acc & we_i & sel_i[0];
    assign rdAcc = acc & ~we_i;

    always_comb begin
        readMux = 32'h0000_0000;
        unique case (regAdr)
            OFS_BUF: readMux[7:0] = s.buffer;
            OFS_CON: readMux[7:0] = {s.write_collision_flag, s.ov, s.en, s.clock_polarity_release_bit, s.mode};
            OFS_STAT: readMux[7:0] = {s.sample_phase_bit, s.cke, s.dataAddr,
                s.stopSeen, s.startSeen, s.readWrite, s.updAddr,
                s.bufFull};
            OFS_ADDR: readMux[7:0] = s.slvAddr;
            OFS_DIR: readMux[3:0] = ~s.dirOut;
            OFS_IRQ: readMux[1:0] = {s.irqEn, s.irqFlag};
            default: readMux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    logic lead;
    logic trail;
    logic sample;
    logic launch;
    logic tick;
    logic spiActive;
    logic hit;
    logic firstHit;
    logic [7:0] srIn;
    logic [1:0] msel;

    always_comb begin
        n = s;
        lead = 1'b0;
        trail = 1'b0;
        tick = 1'b0;
        hit = 1'b0;
        firstHit = 1'b0;
        sample = 1'b0;
        launch = 1'b0;
        spiActive = 1'b0;
        srIn = {s.sr[6:0], sdiBit};
        msel = (s.mode[1:0] == 2'b11) ? 2'b10 : s.mode[1:0];
        // Synchronisers
        n.sclS = {s.sclS[1:0], pinIn.sclIn};
        n.sdaS = {s.sdaS[1:0], pinIn.sdaIn};
        n.ssnS = {s.ssnS[0], pinIn.ssnIn};
        // Bus access; ack one cycle after the request
        n.ack = cyc_i & stb_i & ~s.ack;
        if (n.ack) n.rdat = readMux;
        if (wrLow) begin
            unique case (regAdr)
                OFS_CON: begin
                    n.write_collision_flag = dat_i[CON_WRITE_COLLISION_FLAG];
                    n.ov = dat_i[CON_OV];
                    n.en = dat_i[CON_EN];
                    n.clock_polarity_release_bit = dat_i[CON_CKP];
                    n.mode = dat_i[3:0];
                end
                OFS_STAT: begin
                    n.sample_phase_bit = dat_i[ST_SMP];
                    n.cke = dat_i[ST_CKE];
                end
                OFS_ADDR: begin
                    n.slvAddr = dat_i[7:0];
                    n.updAddr = 1'b0;
                end
                OFS_DIR: n.dirOut = ~dat_i[3:0];
                OFS_IRQ: begin
                    n.irqFlag = dat_i[IRQ_FLAG];
                    n.irqEn = dat_i[IRQ_EN];
                end
                OFS_BUF: begin
                    if ((s.en && (isSpiSlave || isSpiMaster) &&
                        (s.cnt != 4'h0 || s.busy)) ||
                        (s.en && s.ist == I_TX)) begin
                        n.write_collision_flag = 1'b1;
                    end else begin
                        n.buffer = dat_i[7:0];
                        n.sr = dat_i[7:0];
                        n.outBit = dat_i[7];
                        if (s.en && isSpiMaster) begin
                            n.busy = 1'b1;
                            n.edges = 5'h00;
                            n.div = 8'(DIV_HALF - 1);
                        end
                    end
                end
                default: ;
            endcase
        end
        if (rdAcc && regAdr == OFS_BUF) n.bufFull = 1'b0;
        // Disabled port holds the engines at rest
        if (!s.en) begin
            n.cnt = 4'h0;
            n.busy = 1'b0;
            n.intSck = s.clock_polarity_release_bit;
            n.ist = I_IDLE;
            n.phase = 2'b00;
            n.tenMatched = 1'b0;
            n.startSeen = 1'b0;
            n.stopSeen = 1'b0;
        end else if (isSpiSlave || isSpiMaster) begin
            // Internal clock of the master stops while asleep
            if (isSpiMaster && s.busy && !sleep) begin
                if (s.div == 8'h00) begin
                    tick = 1'b1;
                    n.div = 8'((DIV_HALF << (2 * msel)) - 1);
                    n.intSck = ~s.intSck;
                    n.edges = s.edges + 5'h01;
                    if (s.edges == EDGE_LAST) n.busy = 1'b0;
                end else begin
                    n.div = s.div - 8'h01;
                end
            end
            if (isSpiMaster && !s.busy) n.intSck = s.clock_polarity_release_bit;
            if (isSpiMaster) begin
                lead = tick & (s.intSck == s.clock_polarity_release_bit);
                trail = tick & (s.intSck != s.clock_polarity_release_bit);
            end else begin
                lead = s.clock_polarity_release_bit ? sclFall : sclRise;
                trail = s.clock_polarity_release_bit ? sclRise : sclFall;
            end
            sample = s.cke ? lead : trail;
            launch = s.cke ? trail : lead;
            spiActive = isSpiMaster ? s.busy :
                (s.mode != MODE_SPI_SS) | ~ssHigh;
            if (isSpiSlave && s.mode == MODE_SPI_SS && ssHigh) begin
                n.cnt = 4'h0;
            end else if (spiActive) begin
                if (launch) n.outBit = s.sr[7];
                if (sample) begin
                    n.sr = srIn;
                    n.cnt = s.cnt + 4'h1;
                    if (s.cnt == BIT_LAST) begin
                        n.cnt = 4'h0;
                        n.irqFlag = 1'b1;
                        if (s.bufFull) begin
                            n.ov = 1'b1;
                        end else begin
                            n.buffer = srIn;
                            n.bufFull = 1'b1;
                        end
                    end
                end
            end
        end else if (isI2cSlave) begin
            if (startCond) begin
                n.startSeen = 1'b1;
                n.stopSeen = 1'b0;
                n.ist = I_RX;
                n.cnt = 4'h0;
                n.phase = 2'b00;
                if (ssIrq) n.irqFlag = 1'b1;
            end else if (stopCond) begin
                n.stopSeen = 1'b1;
                n.startSeen = 1'b0;
                n.ist = I_IDLE;
                n.tenMatched = 1'b0;
                if (ssIrq) n.irqFlag = 1'b1;
            end else begin
                unique case (s.ist)
                    I_IDLE: ;
                    I_RX: begin
                        if (sclRise) begin
                            n.sr = srIn;
                            n.cnt = s.cnt + 4'h1;
                        end
                        if (sclFall && s.cnt == BIT_ACK) begin
                            if (isTen) begin
                                firstHit = (s.sr[7:3] == TEN_HDR) &&
                                    (s.sr[2:1] == s.slvAddr[2:1]) &&
                                    (!s.sr[0] || s.tenMatched);
                            end else begin
                                firstHit = (s.sr[7:1] ==
                                    s.slvAddr[7:1]);
                            end
                            unique case (s.phase)
                                2'b00: hit = firstHit;
                                2'b01: hit = (s.sr == s.slvAddr);
                                default: hit = 1'b1;
                            endcase
                            if (!hit) begin
                                n.ist = I_IDLE;
                            end else begin
                                n.ist = I_ACK;
                                n.holdReq = 1'b0;
                                n.ackBit = ~s.bufFull & ~s.ov;
                                if (!s.bufFull && !s.ov) begin
                                    n.buffer = s.sr;
                                    n.bufFull = 1'b1;
                                end
                                if (s.bufFull) n.ov = 1'b1;
                                n.dataAddr = (s.phase == 2'b10);
                                if (s.phase == 2'b00) begin
                                    n.readWrite = s.sr[0];
                                    if (s.sr[0]) begin
                                        n.holdReq = 1'b1;
                                        n.phase = 2'b10;
                                    end else if (isTen) begin
                                        n.updAddr = 1'b1;
                                        n.holdReq = 1'b1;
                                        n.phase = 2'b01;
                                    end else begin
                                        n.phase = 2'b10;
                                    end
                                end else if (s.phase == 2'b01) begin
                                    n.updAddr = 1'b1;
                                    n.holdReq = 1'b1;
                                    n.tenMatched = 1'b1;
                                    n.phase = 2'b10;
                                end
                            end
                        end
                    end
                    I_ACK: begin
                        if (sclFall) begin
                            n.irqFlag = 1'b1;
                            n.cnt = 4'h0;
                            if (s.holdReq) begin
                                n.ist = I_HOLD;
                                if (s.readWrite) n.clock_polarity_release_bit = 1'b0;
                            end else begin
                                n.ist = I_RX;
                            end
                        end
                    end
                    I_HOLD: begin
                        // Clock stays low until address update and release
                        if (!s.updAddr && s.clock_polarity_release_bit) begin
                            n.ist = s.readWrite ? I_TX : I_RX;
                            n.cnt = 4'h0;
                        end
                    end
                    I_TX: begin
                        if (sclFall) begin
                            n.sr = {s.sr[6:0], 1'b0};
                            n.cnt = s.cnt + 4'h1;
                            if (s.cnt == BIT_LAST) n.ist = I_MACK;
                        end
                    end
                    I_MACK: begin
                        if (sclRise) begin
                            n.ackBit = ~sdiBit;
                            if (sdiBit) begin
                                n.ist = I_IDLE;
                                n.phase = 2'b00;
                            end
                        end else if (sclFall) begin
                            n.irqFlag = 1'b1;
                            n.clock_polarity_release_bit = 1'b0;
                            n.ist = I_HOLD;
                            n.dataAddr = 1'b1;
                        end
                    end
                    default: n.ist = I_IDLE;
                endcase
            end
        end else begin
            n.ist = I_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    logic i2cPins;
    logic sclLow;
    logic sdaLow;
    logic sckDrive;
    logic sdoDrive;

    assign i2cPins = s.en & isI2c & ~s.dirOut[0] & ~s.dirOut[1];
    assign sclLow = i2cPins & (s.ist == I_HOLD);
    assign sdaLow = i2cPins & (((s.ist == I_ACK) & s.ackBit) |
        ((s.ist == I_TX) & ~s.sr[7]));
    assign sckDrive = s.en & isSpiMaster & s.dirOut[0];
    assign sdoDrive = s.en & s.dirOut[2] & (isSpiMaster |
        (isSpiSlave & ((s.mode != MODE_SPI_SS) | ~ssHigh)));

    assign pinOut.sclOut = isSpiMaster ? s.intSck : 1'b0;
    assign pinOut.sclOe_n = ~(sckDrive | sclLow);
    assign pinOut.sdaOut = 1'b0;
    assign pinOut.sdaOe_n = ~sdaLow;
    assign pinOut.sdoOut = s.outBit;
    assign pinOut.sdoOe_n = ~sdoDrive;
    assign dat_o = s.rdat;
    assign ack_o = s.ack;
    assign portIrq = s.irqFlag;
    assign wakeReq = sleep & s.irqFlag & s.irqEn;
endmodule : ssp_sync_serial

// ==== ssp_sync_serial_tb_top.sv ====
`timescale 1ns/1ns
module ssp_sync_serial_tb_top;
    import ssp_pkg::*;
    typedef struct packed {
        logic clock_polarity_release_bit;
        logic cke;
        logic slp;
        logic [7:0] tx;
        logic [7:0] mosi;
    } ssp_row_t;
    logic clk, rstn, cyc, stb, we, sleep, ack, portIrq, wakeReq;
    logic [7:0] adr, v;
    logic [31:0] wdat, rdat;
    logic [8:0] r9;
    ssp_pin_in_t pinIn;
    ssp_pin_out_t pinOut;
    int err_total;
    int checked;
    ssp_row_t rows [4] = '{'{1'h0, 1'h1, 1'h0, 8'hA5, 8'h3C},
        '{1'h0, 1'h0, 1'h1, 8'h96, 8'h5A},
        '{1'h1, 1'h1, 1'h0, 8'h0F, 8'hF0},
        '{1'h1, 1'h0, 1'h0, 8'h81, 8'h7E}};
    ssp_sync_serial #(.DIV_HALF(1)) ssp_sync_serial_inst (.clk(clk),
        .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .sleep(sleep), .pinIn(pinIn), .pinOut(pinOut),
        .portIrq(portIrq), .wakeReq(wakeReq));
    ssp_far_master ssp_far_master_inst (.pinOut(pinOut), .pinIn(pinIn));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, 24'h0, d};
        do @(posedge clk); while (ack !== 1'h1);
        v = rdat[7:0];
        {cyc, stb} <= 2'h0;
    endtask : wb
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, m, e);
        wb(1'h0, a, 8'h00);
        chk(v & m, e);
    endtask : rdc
    task automatic conclude;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    //////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, adr, wdat, sleep, rstn} = '0;
        err_total = 0;
        checked = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        rdc(OFS_CON, 8'hFF, 8'h00);
        rdc(OFS_DIR, 8'hFF, 8'h0F);
        rdc(8'h20, 8'hFF, 8'h00);
        wb(1'h1, OFS_DIR, 8'h0B);
        wb(1'h1, OFS_IRQ, 8'h02);
        foreach (rows[i]) begin
            wb(1'h1, OFS_CON, 8'h00);
            wb(1'h1, OFS_STAT, {1'h0, rows[i].cke, 6'h00});
            wb(1'h1, OFS_CON, {3'h1, rows[i].clock_polarity_release_bit, MODE_SPI_SS});
            wb(1'h1, OFS_BUF, rows[i].tx);
            sleep <= rows[i].slp;
            ssp_far_master_inst.spi(rows[i].clock_polarity_release_bit, rows[i].cke,
                rows[i].mosi, 4'h8, v);
            chk(v, rows[i].tx);
            chk({7'h0, wakeReq}, {7'h0, rows[i].slp});
            sleep <= 1'h0;
            rdc(OFS_IRQ, 8'h01, 8'h01);
            rdc(OFS_BUF, 8'hFF, rows[i].mosi);
            rdc(OFS_STAT, 8'h01, 8'h00);
            wb(1'h1, OFS_IRQ, 8'h02);
        end
        // Aborted byte, then a full byte and one refused for overflow
        ssp_far_master_inst.spi(1'h1, 1'h0, 8'hFF, 4'h3, v);
        chk({7'h0, pinOut.sdoOe_n}, 8'h01);
        ssp_far_master_inst.spi(1'h1, 1'h0, 8'h3C, 4'h8, v);
        ssp_far_master_inst.spi(1'h1, 1'h0, 8'hC3, 4'h8, v);
        rdc(OFS_BUF, 8'hFF, 8'h3C);
        rdc(OFS_CON, 8'h40, 8'h40);
        wb(1'h1, OFS_CON, 8'h00);
        rdc(OFS_CON, 8'h40, 8'h00);
        ssp_far_master_inst.spi(1'h1, 1'h0, 8'h55, 4'h8, v);
        rdc(OFS_STAT, 8'h01, 8'h00);
        // I2C slave, 7-bit address
        wb(1'h1, OFS_ADDR, 8'h5A);
        wb(1'h1, OFS_CON, {4'h2, MODE_I2C_7});
        ssp_far_master_inst.i2c(1'h1, {8'h5A, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h00);
        rdc(OFS_BUF, 8'hFF, 8'h5A);
        rdc(OFS_STAT, 8'h05, 8'h00);
        wb(1'h1, OFS_IRQ, 8'h02);
        ssp_far_master_inst.i2c(1'h0, {8'h77, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h00);
        rdc(OFS_STAT, 8'h01, 8'h01);
        rdc(OFS_IRQ, 8'h01, 8'h01);
        wb(1'h1, OFS_IRQ, 8'h02);
        ssp_far_master_inst.i2c(1'h0, {8'h88, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h01);
        rdc(OFS_BUF, 8'hFF, 8'h77);
        rdc(OFS_IRQ, 8'h01, 8'h01);
        ssp_far_master_inst.stop();
        wb(1'h1, OFS_CON, {4'h2, MODE_I2C_7});
        ssp_far_master_inst.i2c(1'h1, {8'h40, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h01);
        ssp_far_master_inst.i2c(1'h1, {8'h5B, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h00);
        repeat (4) @(posedge clk);
        chk({7'h0, pinOut.sclOe_n}, 8'h00);
        rdc(OFS_STAT, 8'h04, 8'h04);
        rdc(OFS_BUF, 8'hFF, 8'h5B);
        wb(1'h1, OFS_BUF, 8'hA5);
        wb(1'h1, OFS_CON, {4'h3, MODE_I2C_7});
        ssp_far_master_inst.i2c(1'h0, 9'h1FF, r9);
        chk(r9[8:1], 8'hA5);
        // After the master's refusal a byte without start is ignored
        ssp_far_master_inst.i2c(1'h0, {8'h5A, 1'h1}, r9);
        chk({7'h0, r9[0]}, 8'h01);
        ssp_far_master_inst.stop();
        conclude();
    end
    initial begin
        #300000;
        err_total++;
        conclude();
    end
endmodule : ssp_sync_serial_tb_top
